//--- icp_host.sv
`timescale 1ns/1ps
module icp_host (
    // clock
    input  wire logic       clk,
    // strobes and data driven by the processor
    output logic            cs_n,
    output logic            rd_n,
    output logic            wr_n,
    output logic            a0,
    output logic      [7:0] data_in,
    output logic            ack_n,
    // device answer
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe_n
);
    initial begin
        cs_n    = 1'h1;
        rd_n    = 1'h1;
        wr_n    = 1'h1;
        a0      = 1'h0;
        data_in = 8'h5A;
        ack_n   = 1'h1;
    end

    // one setup or command byte; released lines show the inverse byte
    task automatic wr(input logic adr, input logic [7:0] d);
        @(posedge clk);
        #1;
        cs_n    = 1'h0;
        wr_n    = 1'h0;
        a0      = adr;
        data_in = d;
        @(posedge clk);
        #1;
        cs_n    = 1'h1;
        wr_n    = 1'h1;
        data_in = ~d;
        @(posedge clk);
    endtask

    task automatic rd(input logic adr, output logic [7:0] d);
        @(posedge clk);
        #1;
        cs_n = 1'h0;
        rd_n = 1'h0;
        a0   = adr;
        repeat (3) @(posedge clk);
        #1;
        d    = data_out;
        cs_n = 1'h1;
        rd_n = 1'h1;
        repeat (2) @(posedge clk);
    endtask

    // caller issues two or three of these per sequence, per cpu family
    task automatic ack(output logic [7:0] d, output logic oe_n);
        @(posedge clk);
        #1;
        ack_n = 1'h0;
        repeat (3) @(posedge clk);
        #1;
        d     = data_out;
        oe_n  = data_oe_n;
        ack_n = 1'h1;
        repeat (2) @(posedge clk);
    endtask
endmodule

//--- icp_if.sv
`timescale 1ns/1ps
interface icp_sel_if;
    logic [7:0] req;
    logic       any;
    logic [2:0] lvl;
    modport ctl (output req, input any, input lvl);
    modport rsv (input req, output any, output lvl);
endinterface

interface icp_fmt_if;
    logic [1:0] pulse;
    logic       mode16;
    logic       spacing4;
    logic [2:0] base_low;
    logic [7:0] base_high;
    logic [2:0] lvl;
    logic [7:0] vec;
    modport ctl (output pulse, output mode16, output spacing4, output base_low,
                 output base_high, output lvl, input vec);
    modport fmt (input pulse, input mode16, input spacing4, input base_low,
                 input base_high, input lvl, output vec);
endinterface

//--- icp_pkg.sv
package icp_pkg;
    // widths and levels
    localparam int          LVL_N          = 8;
    localparam int          LVL_W          = 3;
    // register steering by the address line
    localparam logic        ADDR_LOW       = 1'h0;
    localparam logic        ADDR_HIGH      = 1'h1;
    // init_word_one fields
    localparam int          W1_TAG         = 4;
    localparam int          W1_LEVEL_TRIG  = 3;
    localparam int          W1_SPACING     = 2;
    localparam int          W1_SINGLE      = 1;
    localparam int          W1_NEED_FOURTH = 0;
    // init_word_four fields
    localparam int          W4_NESTING     = 4;
    localparam int          W4_BUFFERED    = 3;
    localparam int          W4_MASTER      = 2;
    localparam int          W4_AUTO_END    = 1;
    localparam int          W4_CPU_FAMILY  = 0;
    // operation word fields
    localparam int          OW_SELECT      = 3;
    localparam int          OW2_SPECIFIC   = 6;
    localparam int          OW2_END        = 5;
    localparam int          OW3_SET_MASK   = 6;
    localparam int          OW3_MASK_MODE  = 5;
    localparam int          OW3_POLL       = 2;
    localparam int          OW3_READ_REG   = 1;
    localparam int          OW3_READ_ISR   = 0;
    // fixed bytes and reset values
    localparam logic [7:0]  CALL_OPCODE    = 8'hCD;
    localparam logic [7:0]  BYTE_ZERO      = 8'h00;
    localparam logic [7:0]  EDGE_ARMED     = 8'hFF;
    localparam logic [2:0]  LVL_DEFAULT    = 3'h7;
    localparam logic [2:0]  SLAVE_ID_INIT  = 3'h7;
    // acknowledge pulse index
    localparam logic [1:0]  PULSE_CALL     = 2'h0;
    localparam logic [1:0]  PULSE_LOW      = 2'h1;
    localparam logic [1:0]  PULSE_HIGH     = 2'h2;

    typedef enum logic [4:0] {
        ICP_UNINIT = 5'h01,
        ICP_W2     = 5'h02,
        ICP_W3     = 5'h04,
        ICP_W4     = 5'h08,
        ICP_READY  = 5'h10
    } icp_init_t;

    typedef struct packed {
        icp_init_t   st;
        logic [7:0]  init_word_one;
        logic [7:0]  init_word_two;
        logic [7:0]  init_word_three;
        logic [7:0]  init_word_four;
        logic [2:0]  slave_id;
        logic [7:0]  channel_inhibit_bits;
        logic [7:0]  pending_request_bits;
        logic [7:0]  in_service_bits;
        logic [7:0]  req_prev;
        logic        wr_prev;
        logic        rd_prev;
        logic        ack_prev;
        logic        special_mask;
        logic        read_isr;
        logic        poll_armed;
        logic [1:0]  ack_idx;
        logic [2:0]  ack_lvl;
        logic        ack_drive;
        logic        rd_drive;
        logic [7:0]  bus_byte;
        logic [2:0]  cas_code;
        logic        intr;
    } icp_state_t;
endpackage

//--- icp_prio.sv
`timescale 1ns/1ps
module icp_prio #(
    parameter int N = icp_pkg::LVL_N
) (
    // request set and winner
    icp_sel_if.rsv sel
);
    import icp_pkg::*;

    if (N != LVL_N) begin : g_chk
        $error("icp_prio serves exactly eight levels");
    end

    // scan from the lowest rank so that level zero ends up winning
    always_comb begin
        sel.any = |sel.req;
        sel.lvl = LVL_DEFAULT;
        for (int i = N - 1; i >= 0; i--) begin
            if (sel.req[i]) begin
                sel.lvl = 3'(i);
            end
        end
    end
endmodule

//--- icp_top.sv
`timescale 1ns/1ps
module icp_top (
    // clock, reset, enable
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    // processor bus
    input  wire logic       cs_n,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic       a0,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe_n,
    // interrupt handshake
    input  wire logic       interrupt_acknowledge_pulse_n,
    output logic            intr,
    // peripheral requests
    input  wire logic [7:0] request_inputs,
    // cascade lines
    input  wire logic [2:0] cas_in,
    output logic      [2:0] cas_out,
    output logic            cas_oe_n,
    // primary strap or buffer enable pin
    input  wire logic       primary_pin_or_buffer_enable_in,
    output logic            primary_pin_or_buffer_enable_out,
    output logic            primary_pin_or_buffer_enable_oe_n
);
    import icp_pkg::*;

    icp_state_t s;
    icp_state_t next_s;

    icp_sel_if r_req ();
    icp_sel_if r_isr ();
    icp_fmt_if fmt ();

    icp_prio u_req (.sel(r_req));
    icp_prio u_isr (.sel(r_isr));
    icp_vecfmt u_fmt (.f(fmt));

    logic       wr_act;
    logic       rd_act;
    logic       ack_act;
    logic       wr_start;
    logic       rd_start;
    logic       ack_start;
    logic       ack_end;
    logic       ready;
    logic       level_trig;
    logic       single;
    logic       need_fourth;
    logic       buffered;
    logic       is_master;
    logic       mode16;
    logic       auto_end;
    logic       nesting;
    logic       setup_wr;
    logic       int_cond;
    logic       has_data;
    logic       supplier;
    logic       last_pulse;
    logic [7:0] rise;
    logic [7:0] req_bit;
    logic [7:0] ack_bit;

    assign wr_act    = !cs_n && !wr_n;
    assign rd_act    = !cs_n && !rd_n;
    assign ack_act   = !interrupt_acknowledge_pulse_n;
    assign wr_start  = wr_act && !s.wr_prev;
    assign rd_start  = rd_act && !s.rd_prev;
    assign ack_start = ack_act && !s.ack_prev;
    assign ack_end   = !ack_act && s.ack_prev;
    assign ready     = (s.st == ICP_READY);

    assign level_trig  = s.init_word_one[W1_LEVEL_TRIG];
    assign single      = s.init_word_one[W1_SINGLE];
    assign need_fourth = s.init_word_one[W1_NEED_FOURTH];
    assign buffered    = s.init_word_four[W4_BUFFERED];
    assign mode16      = s.init_word_four[W4_CPU_FAMILY];
    assign auto_end    = s.init_word_four[W4_AUTO_END];
    assign nesting     = s.init_word_four[W4_NESTING];
    // role bit only counts when buffered; otherwise the strap pin decides
    assign is_master   = buffered ? s.init_word_four[W4_MASTER]
                                  : primary_pin_or_buffer_enable_in;
    assign setup_wr    = wr_start && (a0 == ADDR_LOW) && data_in[W1_TAG];

    // masked requests feed the resolver
    assign r_req.req = s.pending_request_bits & ~s.channel_inhibit_bits;
    // special mask mode lets masked service levels stop blocking
    assign r_isr.req = s.special_mask ? (s.in_service_bits & ~s.channel_inhibit_bits)
                                      : s.in_service_bits;
    assign req_bit   = 8'h01 << r_req.lvl;
    assign ack_bit   = 8'h01 << s.ack_lvl;
    assign rise      = request_inputs & ~s.req_prev;

    // nesting: equal level may re-interrupt only through a slave input
    assign int_cond = ready && r_req.any &&
                      (!r_isr.any || (r_req.lvl < r_isr.lvl) ||
                       (nesting && is_master && (r_req.lvl == r_isr.lvl) &&
                        s.init_word_three[r_req.lvl]));

    assign has_data   = mode16 ? (s.ack_idx == PULSE_LOW) : 1'b1;
    assign last_pulse = mode16 ? (s.ack_idx == PULSE_LOW) : (s.ack_idx == PULSE_HIGH);

    always_comb begin
        supplier = 1'b1;
        if (!single) begin
            if (is_master) begin
                supplier = (s.ack_idx == PULSE_CALL) ||
                           !s.init_word_three[s.ack_lvl];
            end else begin
                supplier = (s.ack_idx != PULSE_CALL) && (cas_in == s.slave_id);
            end
        end
    end

    assign fmt.pulse     = s.ack_idx;
    assign fmt.mode16    = mode16;
    assign fmt.spacing4  = s.init_word_one[W1_SPACING];
    assign fmt.base_low  = s.init_word_one[7:5];
    assign fmt.base_high = s.init_word_two;
    assign fmt.lvl       = s.ack_lvl;

    always_comb begin
        next_s          = s;
        next_s.wr_prev  = wr_act;
        next_s.rd_prev  = rd_act;
        next_s.ack_prev = ack_act;
        next_s.req_prev = request_inputs;
        next_s.intr     = int_cond;
        next_s.rd_drive = rd_act;

        // register writes
        if (setup_wr) begin
            next_s.init_word_one        = data_in;
            next_s.st                   = ICP_W2;
            next_s.channel_inhibit_bits = BYTE_ZERO;
            next_s.pending_request_bits = BYTE_ZERO;
            next_s.req_prev             = EDGE_ARMED;
            next_s.slave_id             = SLAVE_ID_INIT;
            next_s.special_mask         = 1'b0;
            next_s.read_isr             = 1'b0;
            next_s.poll_armed           = 1'b0;
            next_s.ack_idx              = PULSE_CALL;
            next_s.ack_drive            = 1'b0;
            next_s.cas_code             = LVL_DEFAULT;
            if (!data_in[W1_NEED_FOURTH]) begin
                next_s.init_word_four = BYTE_ZERO;
            end
        end else if (wr_start && (a0 == ADDR_LOW) && ready) begin
            if (data_in[OW_SELECT]) begin
                if (data_in[OW3_SET_MASK]) begin
                    next_s.special_mask = data_in[OW3_MASK_MODE];
                end
                if (data_in[OW3_POLL]) begin
                    next_s.poll_armed = 1'b1;
                end else if (data_in[OW3_READ_REG]) begin
                    next_s.read_isr = data_in[OW3_READ_ISR];
                end
            end else if (data_in[OW2_END]) begin
                if (data_in[OW2_SPECIFIC]) begin
                    next_s.in_service_bits = s.in_service_bits & ~(8'h01 << data_in[2:0]);
                end else if (r_isr.any) begin
                    next_s.in_service_bits = s.in_service_bits & ~(8'h01 << r_isr.lvl);
                end
            end
        end else if (wr_start && (a0 == ADDR_HIGH)) begin
            case (s.st)
                ICP_W2: begin
                    next_s.init_word_two = data_in;
                    if (single) begin
                        next_s.st = need_fourth ? ICP_W4 : ICP_READY;
                    end else begin
                        next_s.st = ICP_W3;
                    end
                end
                ICP_W3: begin
                    next_s.init_word_three = data_in;
                    next_s.slave_id        = data_in[2:0];
                    next_s.st              = need_fourth ? ICP_W4 : ICP_READY;
                end
                ICP_W4: begin
                    next_s.init_word_four = data_in;
                    next_s.st             = ICP_READY;
                end
                ICP_READY: next_s.channel_inhibit_bits = data_in;
                default:   next_s.st = s.st;
            endcase
        end

        // status reads
        if (rd_start) begin
            if (a0 == ADDR_HIGH) begin
                next_s.bus_byte = s.channel_inhibit_bits;
            end else if (s.poll_armed) begin
                next_s.bus_byte   = {r_req.any, 4'h0, r_req.lvl};
                next_s.poll_armed = 1'b0;
                if (r_req.any) begin
                    next_s.in_service_bits      = next_s.in_service_bits | req_bit;
                    next_s.pending_request_bits = next_s.pending_request_bits & ~req_bit;
                end
            end else begin
                next_s.bus_byte = s.read_isr ? s.in_service_bits
                                             : s.pending_request_bits;
            end
        end

        // acknowledge sequence
        if (ack_start && ready) begin
            if (s.ack_idx == PULSE_CALL) begin
                next_s.ack_lvl = r_req.lvl;
                if (r_req.any) begin
                    next_s.in_service_bits      = next_s.in_service_bits | req_bit;
                    next_s.pending_request_bits = next_s.pending_request_bits & ~req_bit;
                end
            end
            next_s.bus_byte  = fmt.vec;
            next_s.ack_drive = has_data && supplier;
        end
        if (ack_end && ready) begin
            next_s.ack_drive = 1'b0;
            if (s.ack_idx == PULSE_CALL) begin
                next_s.cas_code = s.ack_lvl;
            end
            if (last_pulse) begin
                next_s.ack_idx = PULSE_CALL;
                if (auto_end) begin
                    next_s.in_service_bits = next_s.in_service_bits & ~ack_bit;
                end
            end else begin
                next_s.ack_idx = s.ack_idx + 2'h1;
            end
        end

        // request capture; a new edge wins over a same-cycle clear except the setup clear
        if (level_trig) begin
            next_s.pending_request_bits = request_inputs;
        end else if (!setup_wr) begin
            next_s.pending_request_bits = next_s.pending_request_bits | rise;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s         <= '0;
            s.st      <= ICP_UNINIT;
            s.ack_idx <= PULSE_CALL;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign data_out  = s.bus_byte;
    assign data_oe_n = !(s.ack_drive || s.rd_drive);
    assign intr      = s.intr;
    assign cas_out   = s.cas_code;
    // cascade lines are outputs only on a cascaded master
    assign cas_oe_n  = !(is_master && !single && ready);
    // in buffered mode the pin marks every cycle the data bus is driven
    assign primary_pin_or_buffer_enable_out  = data_oe_n;
    assign primary_pin_or_buffer_enable_oe_n = !buffered;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    call_byte_a: assert property (
        ce && ack_start && ready && !mode16 && s.ack_idx == PULSE_CALL
        |=> data_out == CALL_OPCODE && !data_oe_n == supplier)
        else $error("call opcode not driven on first pulse");

    high_byte_a: assert property (
        ce && ack_start && ready && !mode16 && s.ack_idx == PULSE_HIGH
        |=> data_out == s.init_word_two)
        else $error("third byte is not the upper address");

    space_four_a: assert property (
        ce && ack_start && ready && !mode16 && s.ack_idx == PULSE_LOW &&
        s.init_word_one[W1_SPACING]
        |=> data_out == {s.init_word_one[7:5], s.ack_lvl, 2'b00})
        else $error("four spacing byte wrong");

    space_eight_a: assert property (
        ce && ack_start && ready && !mode16 && s.ack_idx == PULSE_LOW &&
        !s.init_word_one[W1_SPACING]
        |=> data_out == {s.init_word_one[7:6], s.ack_lvl, 3'b000})
        else $error("eight spacing byte wrong");

    vec_first_a: assert property (
        ce && ack_start && ready && mode16 && s.ack_idx == PULSE_CALL
        |=> data_oe_n ##1 data_oe_n)
        else $error("bus driven on first vector pulse");

    vec_byte_a: assert property (
        ce && ack_start && ready && mode16 && s.ack_idx == PULSE_LOW
        |=> data_out == {s.init_word_two[7:3], s.ack_lvl})
        else $error("vector byte format wrong");

    vec_two_a: assert property (
        ce && ack_end && ready && mode16 && s.ack_idx == PULSE_LOW
        |=> s.ack_idx == PULSE_CALL)
        else $error("vector mode did not end after two pulses");

    setup_start_a: assert property (
        ce && setup_wr
        |=> s.st == ICP_W2 && s.channel_inhibit_bits == BYTE_ZERO &&
            s.slave_id == SLAVE_ID_INIT && !s.read_isr && !s.special_mask)
        else $error("first setup word did not restart");

    fourth_zero_a: assert property (
        ce && setup_wr && !data_in[W1_NEED_FOURTH]
        |=> s.init_word_four == BYTE_ZERO)
        else $error("fourth word functions not cleared");

    single_skip_a: assert property (
        ce && wr_start && a0 == ADDR_HIGH && s.st == ICP_W2 && single
        |=> s.st == (need_fourth ? ICP_W4 : ICP_READY))
        else $error("single controller did not skip third word");

    mask_read_a: assert property (
        ce && rd_start && a0 == ADDR_HIGH
        |=> data_out == $past(s.channel_inhibit_bits) && !data_oe_n)
        else $error("mask read returned wrong byte");

    level_trig_a: assert property (
        ce && level_trig && !setup_wr
        |=> s.pending_request_bits == $past(request_inputs))
        else $error("level mode does not follow inputs");

    call_seq_c: cover property (
        ce && ack_end && ready && !mode16 && s.ack_idx == PULSE_HIGH);
    vec_seq_c: cover property (
        ce && ack_end && ready && mode16 && s.ack_idx == PULSE_LOW);
    poll_read_c: cover property (
        ce && rd_start && a0 == ADDR_LOW && s.poll_armed);
    full_setup_c: cover property (
        ce && wr_start && a0 == ADDR_HIGH && s.st == ICP_W4);
endmodule

//--- icp_vecfmt.sv
`timescale 1ns/1ps
module icp_vecfmt (
    // pulse context and vector byte
    icp_fmt_if.fmt f
);
    import icp_pkg::*;

    always_comb begin
        f.vec = BYTE_ZERO;
        if (f.mode16) begin
            f.vec = {f.base_high[7:3], f.lvl};
        end else begin
            case (f.pulse)
                PULSE_CALL: f.vec = CALL_OPCODE;
                PULSE_LOW: begin
                    if (f.spacing4) begin
                        f.vec = {f.base_low, f.lvl, 2'b00};
                    end else begin
                        f.vec = {f.base_low[2:1], f.lvl, 3'b000};
                    end
                end
                PULSE_HIGH: f.vec = f.base_high;
                default:    f.vec = BYTE_ZERO;
            endcase
        end
    end
endmodule

//--- tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) chk(n, e, g)
module tb;
    import icp_pkg::*;
    logic       clk = 1'h0;
    logic       rst_n = 1'h0;
    logic [7:0] req = 8'h00;
    logic       cs_n, rd_n, wr_n, a0, ack_n, data_oe_n, intr, cas_oe_n, pe_out, pe_oe_n;
    logic [7:0] data_in, data_out, d;
    logic [2:0] cas_out;
    logic       oe;
    logic [2:0] cas = 3'h0;
    logic       sp = 1'h1;
    int         n_mismatch = 0;
    int         samples_checked = 0;

    icp_top icp_top_i (.clk(clk), .rst_n(rst_n), .ce(1'h1), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .a0(a0), .data_in(data_in), .data_out(data_out),
        .data_oe_n(data_oe_n), .interrupt_acknowledge_pulse_n(ack_n), .intr(intr),
        .request_inputs(req), .cas_in(cas), .cas_out(cas_out), .cas_oe_n(cas_oe_n),
        .primary_pin_or_buffer_enable_in(sp), .primary_pin_or_buffer_enable_out(pe_out),
        .primary_pin_or_buffer_enable_oe_n(pe_oe_n));
    icp_host icp_host_i (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .a0(a0),
        .data_in(data_in), .ack_n(ack_n), .data_out(data_out), .data_oe_n(data_oe_n));

    always #50 clk = ~clk;

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic final_report;
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // driven pulse: byte and low enable both checked
    task automatic ack_exp(input string nm, input logic [7:0] e);
        icp_host_i.ack(d, oe);
        `CHK(nm, e, d);
        `CHK("ack_oe_n", 8'h00, {7'h0, oe});
    endtask

    task automatic settle(input logic [7:0] r);
        @(posedge clk);
        #1;
        req = r;
        repeat (4) @(posedge clk);
        #1;
    endtask

    initial begin
        repeat (12) @(posedge clk);
        #1;
        rst_n = 1'h1;
        // call mode, spacing four, single, no fourth word
        icp_host_i.wr(ADDR_LOW, 8'h16);
        icp_host_i.wr(ADDR_HIGH, 8'hA5);
        icp_host_i.rd(ADDR_HIGH, d);
        `CHK("mask_after_setup", 8'h00, d);
        `CHK("pin_plain", 8'h01, {7'h0, pe_oe_n});
        icp_host_i.wr(ADDR_HIGH, 8'h08);
        icp_host_i.rd(ADDR_HIGH, d);
        `CHK("mask_readback", 8'h08, d);
        settle(8'h08);
        `CHK("intr_masked", 8'h00, {7'h0, intr});
        settle(8'h4C);
        `CHK("intr_raised", 8'h01, {7'h0, intr});
        ack_exp("call_byte", CALL_OPCODE);
        ack_exp("low_byte4", 8'h08);
        ack_exp("high_byte", 8'hA5);
        icp_host_i.wr(ADDR_LOW, 8'h0B);
        icp_host_i.rd(ADDR_LOW, d);
        `CHK("in_service", 8'h04, d);
        // setup start keeps service bits, so retire level two first
        icp_host_i.wr(ADDR_LOW, 8'h20);
        icp_host_i.rd(ADDR_LOW, d);
        `CHK("eoi_clear", 8'h00, d);
        settle(8'h00);
        // vector mode through the fourth word
        icp_host_i.wr(ADDR_LOW, 8'h13);
        icp_host_i.wr(ADDR_HIGH, 8'h48);
        icp_host_i.wr(ADDR_HIGH, 8'h01);
        icp_host_i.rd(ADDR_HIGH, d);
        `CHK("mask_cleared", 8'h00, d);
        settle(8'h20);
        `CHK("intr_vec", 8'h01, {7'h0, intr});
        icp_host_i.ack(d, oe);
        `CHK("vec_first_oe_n", 8'h01, {7'h0, oe});
        ack_exp("vec_byte", 8'h4D);
        settle(8'h00);
        // fourth word skipped: call mode forced back, no request seen
        icp_host_i.wr(ADDR_LOW, 8'h12);
        icp_host_i.wr(ADDR_HIGH, 8'hC0);
        ack_exp("call_again", CALL_OPCODE);
        ack_exp("low_byte8_l7", 8'h38);
        ack_exp("high_byte2", 8'hC0);
        // buffered cascaded master, auto end, slave behind input three
        icp_host_i.wr(ADDR_LOW, 8'h11);
        icp_host_i.wr(ADDR_HIGH, 8'h40);
        icp_host_i.wr(ADDR_HIGH, 8'h08);
        icp_host_i.wr(ADDR_HIGH, 8'h0E);
        `CHK("pin_buffered", 8'h00, {7'h0, pe_oe_n});
        `CHK("cas_oe_master", 8'h00, {7'h0, cas_oe_n});
        settle(8'h08);
        `CHK("intr_master", 8'h01, {7'h0, intr});
        fork
            ack_exp("m_call", CALL_OPCODE);
            begin
                repeat (3) @(posedge clk);
                #2;
                `CHK("buf_enable", 8'h00, {7'h0, pe_out});
            end
        join
        icp_host_i.ack(d, oe);
        `CHK("m_low_off", 8'h01, {7'h0, oe});
        `CHK("cas_code", 8'h03, {5'h0, cas_out});
        icp_host_i.ack(d, oe);
        `CHK("m_high_off", 8'h01, {7'h0, oe});
        icp_host_i.wr(ADDR_LOW, 8'h0B);
        icp_host_i.rd(ADDR_LOW, d);
        `CHK("auto_end", 8'h20, d);
        // slave with id five, spacing four, no fourth word
        settle(8'h00);
        sp  = 1'h0;
        cas = 3'h5;
        icp_host_i.wr(ADDR_LOW, 8'h14);
        icp_host_i.wr(ADDR_HIGH, 8'h60);
        icp_host_i.wr(ADDR_HIGH, 8'h05);
        `CHK("cas_oe_slave", 8'h01, {7'h0, cas_oe_n});
        settle(8'h10);
        icp_host_i.rd(ADDR_LOW, d);
        `CHK("pend_select", 8'h10, d);
        icp_host_i.ack(d, oe);
        `CHK("s_call_off", 8'h01, {7'h0, oe});
        ack_exp("s_low_byte", 8'h10);
        #1 cas = 3'h2;
        icp_host_i.ack(d, oe);
        `CHK("s_high_off", 8'h01, {7'h0, oe});
        // held request needs a fresh edge; then level mode and poll
        settle(8'h02);
        icp_host_i.wr(ADDR_LOW, 8'h12);
        icp_host_i.wr(ADDR_HIGH, 8'h00);
        settle(8'h02);
        `CHK("rearm", 8'h00, {7'h0, intr});
        icp_host_i.wr(ADDR_LOW, 8'h1A);
        icp_host_i.wr(ADDR_HIGH, 8'h00);
        settle(8'h02);
        `CHK("level_high", 8'h01, {7'h0, intr});
        settle(8'h00);
        `CHK("level_low", 8'h00, {7'h0, intr});
        settle(8'h04);
        icp_host_i.wr(ADDR_LOW, 8'h0C);
        icp_host_i.rd(ADDR_LOW, d);
        `CHK("poll_byte", 8'h82, d);
        final_report();
    end

    // full run is well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        final_report();
    end
endmodule
